// file: shared/mfrw_pkg.sv
// Constants, pin bundle and state codes for the multi-line flash read front end
package mfrw_pkg;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam logic [7:0] OP_QUAD_WORD = 8'hE7;
    localparam logic [7:0] OP_SET_WRAP = 8'h77;
    localparam logic [1:0] CONT_MODE_MATCH = 2'h2;
    localparam int CONT_SEL_LSB = 4;
    localparam int WRAP_DIS_BIT = 4;
    localparam int WRAP_LEN_LSB = 5;
    localparam logic WRAP_DIS_RESET = 1'h1;
    localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [5:0] WRAP_CFG_CLKS = 6'h20;
    localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h04;
    localparam logic [5:0] WORD_DUMMY_CLKS = 6'h02;
    localparam logic [5:0] QPI_MODE_CLKS = 6'h02;
    localparam logic [5:0] QPI_DUMMY_P0 = 6'h04;
    localparam logic [5:0] QPI_DUMMY_P1 = 6'h06;
    localparam logic [5:0] QPI_DUMMY_P2 = 6'h08;
    localparam logic [5:0] QPI_DUMMY_P3 = 6'h08;
    localparam logic [1:0] LANES_1 = 2'h0;
    localparam logic [1:0] LANES_2 = 2'h1;
    localparam logic [1:0] LANES_4 = 2'h2;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] data;
    } mfrw_pins_s;

    typedef struct packed {
        logic dis;
        logic [1:0] len;
    } mfrw_wrap_s;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_CMD = 8'h02,
        ST_ADDR = 8'h04,
        ST_MODE = 8'h08,
        ST_DUMMY = 8'h10,
        ST_DATA = 8'h20,
        ST_WRAP = 8'h40,
        ST_IGNORE = 8'h80
    } mfrw_state_e;
endpackage

// file: verilog/mfrw_top.sv
// Device-side read command front end: dual/quad IO reads, continuous mode, burst wrap
// How it works
// - Dual IO read: address and mode in two bits per clock, data out likewise
// - Reads start anywhere; address steps by one per byte while selected
// - Dual mode bits 10 make next selection start at the address
// - Other mode bits leave continuous mode; next selection needs an opcode
// - Continuous-mode reset command clears continuous state
// - Quad IO read: address, mode four bits per clock, four dummies, data
// - Quad read opcodes are only accepted while the quad enable status bit is set
// - Quad read with mode bits 10 skips the opcode next time
// - Wrap enabled in standard mode wraps inside the aligned page section
// - Four-line command mode quad IO dummies come from parameter: 4, 6, 8, 8
// - Four-line mode counts mode clocks inside dummies; continuous mode stays
// - Quad read never wraps in four-line command mode
// - Word read forces address bit zero low and uses two dummies
// - Word read with mode bits 10 skips the opcode next time
// - Wrap disable bit one disables; length bits give 8 to 64 bytes
// - Wrap setting holds for all later quad and word reads in standard command mode
// - Wrap length survives mode switch; read-parameter load may overwrite it
`timescale 1ns/1ps
module mfrw_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire mfrw_pkg::mfrw_pins_s i_pins,
    input wire logic i_quad_lines_enable_bit,
    input wire logic i_four_line_command_mode,
    input wire logic i_cont_mode_reset,
    input wire logic [1:0] i_read_param_dummy,
    input wire logic i_read_param_load,
    input wire logic [1:0] i_read_param_wrap_len,
    input wire logic i_mem_req_ready,
    input wire logic i_mem_data_valid,
    input wire logic [7:0] i_mem_data,
    output logic [3:0] o_data_out,
    output logic [3:0] o_data_oe_n,
    output logic o_mem_req_valid,
    output logic [23:0] o_mem_addr,
    output logic o_mem_data_ready,
    output logic o_cont_mode_active,
    output mfrw_pkg::mfrw_wrap_s o_wrap_cfg
);
    mfrw_pkg::mfrw_pins_s pins_m_q, pins_q;
    logic sclk_d_q;
    mfrw_pkg::mfrw_state_e st_q;
    logic [5:0] cnt_q, last, dlen_q;
    logic [1:0] lw_q;
    logic [31:0] in_q, in_d;
    logic [7:0] cmd_q, cont_cmd_q;
    logic cont_q, wrap_act_q, fetch_on_q, pend_q;
    mfrw_pkg::mfrw_wrap_s wrap_q;
    logic [23:0] fa_q, fa_next;
    logic [7:0] wmask;
    logic [7:0] fifo_mem [0:1];
    logic wp_q, rp_q;
    logic [1:0] cnt_f_q, cnt_f_d;
    logic [7:0] sh_q;
    logic [3:0] left_q;
    logic rise, fall, sel, phase_end, push, pop, accept, mode_end;
    logic [5:0] dsel;

    // Two-stage synchroniser, third stage for edge finding
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_m_q <= '{cs_n: 1'h1, sclk: 1'h0, data: 4'h0};
            pins_q <= '{cs_n: 1'h1, sclk: 1'h0, data: 4'h0};
            sclk_d_q <= 1'h0;
        end else begin
            pins_m_q <= i_pins;
            pins_q <= pins_m_q;
            sclk_d_q <= pins_q.sclk;
        end
    end

    assign sel = !pins_q.cs_n;
    assign rise = sel && pins_q.sclk && !sclk_d_q;
    assign fall = sel && !pins_q.sclk && sclk_d_q;

    always_comb begin
        unique case (lw_q)
            mfrw_pkg::LANES_4: in_d = {in_q[27:0], pins_q.data};
            mfrw_pkg::LANES_2: in_d = {in_q[29:0], pins_q.data[1:0]};
            default: in_d = {in_q[30:0], pins_q.data[0]};
        endcase
    end

    // Clocks in the present phase less one
    always_comb begin
        unique case (st_q)
            mfrw_pkg::ST_CMD: last = (mfrw_pkg::CMD_BITS >> lw_q) - 6'h01;
            mfrw_pkg::ST_ADDR: last = (mfrw_pkg::ADDR_BITS >> lw_q) - 6'h01;
            mfrw_pkg::ST_MODE: last = (mfrw_pkg::MODE_BITS >> lw_q) - 6'h01;
            mfrw_pkg::ST_DUMMY: last = dlen_q - 6'h01;
            mfrw_pkg::ST_WRAP: last = mfrw_pkg::WRAP_CFG_CLKS - 6'h01;
            default: last = 6'h3F;
        endcase
    end
    assign phase_end = rise && cnt_q == last;
    assign mode_end = phase_end && st_q == mfrw_pkg::ST_MODE;

    // Dummy clocks after the mode byte
    always_comb begin
        if (cmd_q == mfrw_pkg::OP_DUAL_IO) begin
            dsel = 6'h00;
        end else if (cmd_q == mfrw_pkg::OP_QUAD_WORD) begin
            dsel = mfrw_pkg::WORD_DUMMY_CLKS;
        end else if (!i_four_line_command_mode) begin
            dsel = mfrw_pkg::QUAD_DUMMY_CLKS;
        end else begin
            unique case (i_read_param_dummy)
                2'h0: dsel = mfrw_pkg::QPI_DUMMY_P0 - mfrw_pkg::QPI_MODE_CLKS;
                2'h1: dsel = mfrw_pkg::QPI_DUMMY_P1 - mfrw_pkg::QPI_MODE_CLKS;
                2'h2: dsel = mfrw_pkg::QPI_DUMMY_P2 - mfrw_pkg::QPI_MODE_CLKS;
                default: dsel = mfrw_pkg::QPI_DUMMY_P3 - mfrw_pkg::QPI_MODE_CLKS;
            endcase
        end
    end

    // Command sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= mfrw_pkg::ST_IDLE;
            cnt_q <= 6'h00;
            lw_q <= mfrw_pkg::LANES_1;
            in_q <= 32'h0;
            cmd_q <= 8'h00;
            dlen_q <= 6'h00;
        end else if (!sel) begin
            st_q <= mfrw_pkg::ST_IDLE;
            cnt_q <= 6'h00;
        end else if (st_q == mfrw_pkg::ST_IDLE) begin
            if (cont_q) begin
                st_q <= mfrw_pkg::ST_ADDR;
                cmd_q <= cont_cmd_q;
                lw_q <= (cont_cmd_q == mfrw_pkg::OP_DUAL_IO) ? mfrw_pkg::LANES_2 : mfrw_pkg::LANES_4;
            end else begin
                st_q <= mfrw_pkg::ST_CMD;
                lw_q <= i_four_line_command_mode ? mfrw_pkg::LANES_4 : mfrw_pkg::LANES_1;
            end
        end else if (rise) begin
            in_q <= in_d;
            cnt_q <= phase_end ? 6'h00 : cnt_q + 6'h01;
            if (phase_end) begin
                unique case (st_q)
                    mfrw_pkg::ST_CMD: begin
                        cmd_q <= in_d[7:0];
                        st_q <= mfrw_pkg::ST_IGNORE;
                        if (in_d[7:0] == mfrw_pkg::OP_DUAL_IO && !i_four_line_command_mode) begin
                            st_q <= mfrw_pkg::ST_ADDR;
                            lw_q <= mfrw_pkg::LANES_2;
                        end else if ((in_d[7:0] == mfrw_pkg::OP_QUAD_IO || in_d[7:0] == mfrw_pkg::OP_QUAD_WORD)
                                     && i_quad_lines_enable_bit) begin
                            st_q <= mfrw_pkg::ST_ADDR;
                            lw_q <= mfrw_pkg::LANES_4;
                        end else if (in_d[7:0] == mfrw_pkg::OP_SET_WRAP && !i_four_line_command_mode) begin
                            st_q <= mfrw_pkg::ST_WRAP;
                        end
                    end
                    mfrw_pkg::ST_ADDR: st_q <= mfrw_pkg::ST_MODE;
                    mfrw_pkg::ST_MODE: begin
                        dlen_q <= dsel;
                        st_q <= (dsel == 6'h00) ? mfrw_pkg::ST_DATA : mfrw_pkg::ST_DUMMY;
                    end
                    mfrw_pkg::ST_DUMMY: st_q <= mfrw_pkg::ST_DATA;
                    mfrw_pkg::ST_WRAP: st_q <= mfrw_pkg::ST_IGNORE;
                    default: st_q <= st_q;
                endcase
            end
        end
    end

    // Continuous read state; the command's own set wins over a reset request
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cont_q <= 1'h0;
            cont_cmd_q <= 8'h00;
        end else if (mode_end) begin
            cont_q <= in_d[mfrw_pkg::CONT_SEL_LSB +: 2] == mfrw_pkg::CONT_MODE_MATCH;
            cont_cmd_q <= cmd_q;
        end else if (i_cont_mode_reset) begin
            cont_q <= 1'h0;
        end
    end

    // Wrap setting
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wrap_q <= '{dis: mfrw_pkg::WRAP_DIS_RESET, len: mfrw_pkg::WRAP_LEN_RESET};
        end else if (phase_end && st_q == mfrw_pkg::ST_WRAP) begin
            wrap_q.dis <= in_d[mfrw_pkg::WRAP_DIS_BIT];
            wrap_q.len <= in_d[mfrw_pkg::WRAP_LEN_LSB +: 2];
        end else if (i_read_param_load) begin
            wrap_q.len <= i_read_param_wrap_len;
        end
    end

    assign wmask = {2'h0, wrap_q.len == 2'h3, wrap_q.len[1], |wrap_q.len, 3'h7};
    assign fa_next = wrap_act_q ? {fa_q[23:8], (fa_q[7:0] & ~wmask) | ((fa_q[7:0] + 8'h01) & wmask)}
                                : fa_q + 24'h000001;
    assign accept = o_mem_req_valid && i_mem_req_ready;

    // Byte fetcher, one request outstanding
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fetch_on_q <= 1'h0;
            wrap_act_q <= 1'h0;
            fa_q <= 24'h0;
            o_mem_req_valid <= 1'h0;
            o_mem_addr <= 24'h0;
            pend_q <= 1'h0;
        end else begin
            if (i_mem_data_valid && o_mem_data_ready) begin
                pend_q <= 1'h0;
            end
            if (!sel) begin
                fetch_on_q <= 1'h0;
                o_mem_req_valid <= 1'h0;
            end else if (phase_end && st_q == mfrw_pkg::ST_ADDR) begin
                fetch_on_q <= 1'h1;
                fa_q <= (cmd_q == mfrw_pkg::OP_QUAD_WORD) ? {in_d[23:1], 1'h0} : in_d[23:0];
                wrap_act_q <= cmd_q != mfrw_pkg::OP_DUAL_IO && !i_four_line_command_mode
                              && !wrap_q.dis;
            end else if (accept) begin
                o_mem_req_valid <= 1'h0;
                pend_q <= 1'h1;
                fa_q <= fa_next;
            end else if (fetch_on_q && !o_mem_req_valid && !pend_q && cnt_f_q < 2'h2) begin
                o_mem_req_valid <= 1'h1;
                o_mem_addr <= fa_q;
            end
        end
    end

    // Two-entry buffer between fetcher and shifter
    assign push = i_mem_data_valid && o_mem_data_ready && fetch_on_q;
    assign pop = fall && st_q == mfrw_pkg::ST_DATA && left_q == 4'h0 && cnt_f_q != 2'h0;
    always_comb begin
        cnt_f_d = cnt_f_q;
        if (!sel) begin
            cnt_f_d = 2'h0;
        end else if (push && !pop) begin
            cnt_f_d = cnt_f_q + 2'h1;
        end else if (pop && !push) begin
            cnt_f_d = cnt_f_q - 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_f_q <= 2'h0;
            wp_q <= 1'h0;
            rp_q <= 1'h0;
            o_mem_data_ready <= 1'h1;
        end else begin
            cnt_f_q <= cnt_f_d;
            o_mem_data_ready <= cnt_f_d != 2'h2;
            wp_q <= !sel ? 1'h0 : wp_q ^ push;
            rp_q <= !sel ? 1'h0 : rp_q ^ pop;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            fifo_mem[wp_q] <= i_mem_data;
        end
    end

    // Output shifter, updated on falling serial clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_q <= 8'h00;
            left_q <= 4'h0;
            o_data_out <= 4'h0;
        end else if (!sel || st_q != mfrw_pkg::ST_DATA) begin
            left_q <= 4'h0;
        end else if (fall && (left_q != 4'h0 || pop)) begin
            if (lw_q == mfrw_pkg::LANES_4) begin
                o_data_out <= pop ? fifo_mem[rp_q][7:4] : sh_q[7:4];
                sh_q <= pop ? {fifo_mem[rp_q][3:0], 4'h0} : {sh_q[3:0], 4'h0};
                left_q <= pop ? 4'h4 : left_q - 4'h4;
            end else begin
                o_data_out <= {2'h0, pop ? fifo_mem[rp_q][7:6] : sh_q[7:6]};
                sh_q <= pop ? {fifo_mem[rp_q][5:0], 2'h0} : {sh_q[5:0], 2'h0};
                left_q <= pop ? 4'h6 : left_q - 4'h2;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_oe_n <= 4'hF;
        end else if (sel && st_q == mfrw_pkg::ST_DATA) begin
            o_data_oe_n <= (lw_q == mfrw_pkg::LANES_4) ? 4'h0 : 4'hC;
        end else begin
            o_data_oe_n <= 4'hF;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cont_mode_active <= 1'h0;
            o_wrap_cfg <= '{dis: mfrw_pkg::WRAP_DIS_RESET, len: mfrw_pkg::WRAP_LEN_RESET};
        end else begin
            o_cont_mode_active <= cont_q;
            o_wrap_cfg <= wrap_q;
        end
    end

    property p_cont_enter;
        @(posedge i_clk) disable iff (i_rst)
        mode_end && in_d[5:4] == 2'h2 |=> cont_q ##1 o_cont_mode_active;
    endproperty
    a_cont_enter: assert property (p_cont_enter) else $error("mode bits 10 did not enter continuous mode");

    property p_cont_leave;
        @(posedge i_clk) disable iff (i_rst)
        mode_end && in_d[5:4] != 2'h2 |=> !cont_q;
    endproperty
    a_cont_leave: assert property (p_cont_leave) else $error("continuous mode kept after other mode bits");

    property p_cont_reset;
        @(posedge i_clk) disable iff (i_rst)
        i_cont_mode_reset && !mode_end |=> !cont_q ##1 !o_cont_mode_active;
    endproperty
    a_cont_reset: assert property (p_cont_reset) else $error("reset command left continuous mode set");

    property p_qe_gate;
        @(posedge i_clk) disable iff (i_rst)
        phase_end && st_q == mfrw_pkg::ST_CMD && !i_quad_lines_enable_bit && in_d[7:0] == mfrw_pkg::OP_QUAD_IO
        |=> st_q == mfrw_pkg::ST_IGNORE;
    endproperty
    a_qe_gate: assert property (p_qe_gate) else $error("quad read accepted without quad enable");

    property p_linear_step;
        @(posedge i_clk) disable iff (i_rst)
        accept && !wrap_act_q && !(phase_end && st_q == mfrw_pkg::ST_ADDR) |=> fa_q == $past(o_mem_addr) + 24'h000001;
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("linear read address did not step by one");

    property p_wrap_bound;
        @(posedge i_clk) disable iff (i_rst)
        accept && wrap_act_q |=> fa_q[23:6] == $past(fa_q[23:6]) && (fa_q[2:0] == $past(fa_q[2:0]) + 3'h1);
    endproperty
    a_wrap_bound: assert property (p_wrap_bound) else $error("wrapped read left its section");

    property p_qpi_nowrap;
        @(posedge i_clk) disable iff (i_rst)
        phase_end && st_q == mfrw_pkg::ST_ADDR && i_four_line_command_mode |=> !wrap_act_q;
    endproperty
    a_qpi_nowrap: assert property (p_qpi_nowrap) else $error("wrap active in four-line command mode");

    property p_word_align;
        @(posedge i_clk) disable iff (i_rst)
        phase_end && st_q == mfrw_pkg::ST_ADDR && cmd_q == mfrw_pkg::OP_QUAD_WORD |=> !fa_q[0] ##[1:20] !o_mem_addr[0];
    endproperty
    a_word_align: assert property (p_word_align) else $error("word read started on odd address");

    property p_dummy_len;
        @(posedge i_clk) disable iff (i_rst)
        mode_end && cmd_q == mfrw_pkg::OP_QUAD_IO && i_four_line_command_mode && i_read_param_dummy == 2'h1
        |=> dlen_q == 6'h04;
    endproperty
    a_dummy_len: assert property (p_dummy_len) else $error("wrong dummy count in four-line mode");

    property p_wrap_cfg;
        @(posedge i_clk) disable iff (i_rst)
        phase_end && st_q == mfrw_pkg::ST_WRAP |=> wrap_q.dis == $past(in_d[4]) ##1 o_wrap_cfg == $past(wrap_q);
    endproperty
    a_wrap_cfg: assert property (p_wrap_cfg) else $error("wrap bits not latched");

    property p_oe_quad;
        @(posedge i_clk) disable iff (i_rst)
        st_q == mfrw_pkg::ST_DATA && sel && lw_q == mfrw_pkg::LANES_4 |=> o_data_oe_n == 4'h0;
    endproperty
    a_oe_quad: assert property (p_oe_quad) else $error("quad data lines not driven");

    c_dual_read: cover property (@(posedge i_clk) disable iff (i_rst) pop && lw_q == mfrw_pkg::LANES_2);
    c_cont_skip: cover property (@(posedge i_clk) disable iff (i_rst)
        st_q == mfrw_pkg::ST_IDLE && sel && cont_q);
    c_wrap_turn: cover property (@(posedge i_clk) disable iff (i_rst) accept && wrap_act_q && fa_next[2:0] == 3'h0);
    c_wrap_set: cover property (@(posedge i_clk) disable iff (i_rst) phase_end && st_q == mfrw_pkg::ST_WRAP);
endmodule

// file: tb/mfrw_host_model.sv
// Host flash controller model driving select, serial clock and data lines
`timescale 1ns/1ps
module mfrw_host_model (
    input wire logic i_clk,
    input wire logic [3:0] i_dev_out,
    input wire logic [3:0] i_dev_oe_n,
    output mfrw_pkg::mfrw_pins_s o_pins
);
    logic cs_n = 1'b1;
    logic sclk = 1'b0;
    logic ph = 1'b0;
    logic [3:0] drv = 4'h0;
    logic [3:0] en = 4'h0;
    logic [3:0] last = 4'h0;
    logic [3:0] lvl;
    // Released lines with no driver toggle every cycle; unknown enable counts as released
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lvl[i] = (i_dev_oe_n[i] === 1'b0) ? i_dev_out[i] : (en[i] ? drv[i] : ~last[i]);
        end
    end
    always @(posedge i_clk) begin
        last <= lvl;
    end
    assign o_pins = {cs_n, sclk, lvl};
    // Half periods of 12 and 13 cycles give 125 ns
    task half();
        repeat (ph ? 13 : 12) @(negedge i_clk);
        ph = !ph;
    endtask
    // Data set while clock low, sampled at the rise
    task tick(input logic [3:0] v, input logic [3:0] m, output logic [3:0] s);
        drv = v;
        en = m;
        half();
        sclk = 1'b1;
        s = lvl;
        half();
        sclk = 1'b0;
    endtask
    task send(input logic [31:0] v, input int n, input int w);
        logic [3:0] s;
        for (int k = n - w; k >= 0; k -= w) begin
            tick(4'((v >> k) & ((1 << w) - 1)), 4'((1 << w) - 1), s);
        end
    endtask
    task dummy(input int n);
        logic [3:0] s;
        repeat (n) tick(4'h0, 4'h0, s);
    endtask
    task recv(input int w, output logic [7:0] b);
        logic [3:0] s;
        b = 8'h00;
        for (int k = 0; k < 8; k += w) begin
            tick(4'h0, 4'h0, s);
            b = 8'((b << w) | (s & 4'((1 << w) - 1)));
        end
    endtask
    task start_frame();
        cs_n = 1'b0;
        half();
    endtask
    task stop_frame();
        half();
        en = 4'h0;
        cs_n = 1'b1;
        repeat (40) @(negedge i_clk);
    endtask
endmodule

// file: tb/mfrw_top_tb_top.sv
// Self-checking bench for the multi-line flash read front end
`timescale 1ns/1ps
module mfrw_top_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    mfrw_pkg::mfrw_pins_s pins;
    logic qe = 1'b0, four_line_command_mode = 1'b0, cmr = 1'b0, prl = 1'b0;
    logic [1:0] pdum = 2'h0, pwl = 2'h0;
    logic rq_rdy = 1'b0, d_vld = 1'b0, took = 1'b0, saw_full = 1'b0;
    logic [7:0] d_byte = 8'h00;
    logic [3:0] dout, doe_n;
    logic rq_vld, d_rdy, cont;
    logic [23:0] rq_addr, pa = 24'h0;
    mfrw_pkg::mfrw_wrap_s wcfg;
    int pend = 0, nreq = 0, errors = 0, checks = 0;
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    mfrw_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_pins(pins), .i_quad_lines_enable_bit(qe),
        .i_four_line_command_mode(four_line_command_mode), .i_cont_mode_reset(cmr), .i_read_param_dummy(pdum),
        .i_read_param_load(prl), .i_read_param_wrap_len(pwl), .i_mem_req_ready(rq_rdy),
        .i_mem_data_valid(d_vld), .i_mem_data(d_byte), .o_data_out(dout), .o_data_oe_n(doe_n),
        .o_mem_req_valid(rq_vld), .o_mem_addr(rq_addr), .o_mem_data_ready(d_rdy),
        .o_cont_mode_active(cont), .o_wrap_cfg(wcfg));
    mfrw_host_model u_host (.i_clk(i_clk), .i_dev_out(dout), .i_dev_oe_n(doe_n), .o_pins(pins));
    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    always @(posedge i_clk) begin
        took <= d_vld && d_rdy;
        if (!d_rdy) saw_full <= 1'b1;
    end
    // Memory answers three cycles after taking a request
    always @(negedge i_clk) begin
        if (rq_rdy) begin
            rq_rdy <= 1'b0;
        end else if (rq_vld && pend == 0 && !d_vld) begin
            rq_rdy <= 1'b1;
            pa <= rq_addr;
            pend <= 3;
            nreq <= nreq + 1;
        end
        if (took) d_vld <= 1'b0;
        if (pend == 1) begin
            d_vld <= 1'b1;
            d_byte <= mem_byte(pa);
        end
        if (pend != 0) pend <= pend - 1;
    end
    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test();
        $display("Checks %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Read frame: ow opcode bits per clock (0 skips), L section length (0 linear)
    task automatic rd(input int ow, input logic [7:0] op, input int w, input logic [23:0] a,
        input logic [23:0] ae, input logic [7:0] m, input int d, input int n, input int L, input logic [3:0] oe);
        logic [7:0] b;
        logic [23:0] x;
        u_host.start_frame();
        if (ow != 0) u_host.send(32'(op), 8, ow);
        u_host.send(32'(a), 24, w);
        u_host.send(32'(m), 8, w);
        u_host.dummy(d);
        for (int i = 0; i < n; i++) begin
            x = (L == 0) ? ae + 24'(i) : (ae & ~24'(L - 1)) | ((ae + 24'(i)) & 24'(L - 1));
            u_host.recv(w, b);
            check("read byte", 24'(b), 24'(mem_byte(x)));
            check("data oe", 24'(doe_n), 24'(oe));
        end
        u_host.stop_frame();
    endtask
    task automatic set_wrap(input logic [7:0] wb);
        u_host.start_frame();
        u_host.send(32'(mfrw_pkg::OP_SET_WRAP), 8, 1);
        u_host.send(32'h0, 24, 1);
        u_host.send(32'(wb), 8, 1);
        u_host.stop_frame();
        check("wrap cfg", 24'(wcfg), 24'({wb[4], wb[6:5]}));
    endtask
    task t_reset();
        check("oe", 24'(doe_n), 24'h00000F);
        check("req", 24'(rq_vld), 24'h000000);
        check("data ready", 24'(d_rdy), 24'h000001);
        check("cont", 24'(cont), 24'h000000);
        check("wrap cfg", 24'(wcfg), 24'h000004);
        $display("reset test done");
    endtask
    task t_dual();
        rd(1, mfrw_pkg::OP_DUAL_IO, 2, 24'h0012FE, 24'h0012FE, 8'h00, 0, 4, 0, 4'hC);
        check("cont", 24'(cont), 24'h000000);
        rd(1, mfrw_pkg::OP_DUAL_IO, 2, 24'h00A0F0, 24'h00A0F0, 8'h20, 0, 2, 0, 4'hC);
        check("cont", 24'(cont), 24'h000001);
        rd(0, 8'h00, 2, 24'h00B001, 24'h00B001, 8'h10, 0, 2, 0, 4'hC);
        check("cont", 24'(cont), 24'h000000);
        $display("dual test done");
    endtask
    task t_refuse();
        int n0;
        n0 = nreq;
        u_host.start_frame();
        u_host.send(32'(mfrw_pkg::OP_QUAD_IO), 8, 1);
        u_host.send(32'h000100, 24, 4);
        u_host.dummy(12);
        check("oe", 24'(doe_n), 24'h00000F);
        check("requests", 24'(nreq - n0), 24'h000000);
        u_host.stop_frame();
        $display("refuse test done");
    endtask
    task t_quad();
        qe = 1'b1;
        rd(1, mfrw_pkg::OP_QUAD_IO, 4, 24'h000310, 24'h000310, 8'h20, 4, 4, 0, 4'h0);
        check("buffer full seen", 24'(saw_full), 24'h000001);
        check("cont", 24'(cont), 24'h000001);
        rd(0, 8'h00, 4, 24'h000400, 24'h000400, 8'h20, 4, 2, 0, 4'h0);
        cmr = 1'b1;
        @(negedge i_clk);
        cmr = 1'b0;
        repeat (3) @(negedge i_clk);
        check("cont", 24'(cont), 24'h000000);
        rd(1, mfrw_pkg::OP_QUAD_IO, 4, 24'h000411, 24'h000411, 8'h00, 4, 1, 0, 4'h0);
        $display("quad test done");
    endtask
    task t_wrap();
        for (int l = 0; l < 4; l++) begin
            set_wrap(8'(l << 5));
            rd(1, mfrw_pkg::OP_QUAD_IO, 4, 24'h000500 | 24'((8 << l) - 1), 24'h000500 | 24'((8 << l) - 1),
                8'h00, 4, 2, 8 << l, 4'h0);
        end
        rd(1, mfrw_pkg::OP_QUAD_WORD, 4, 24'h00053F, 24'h00053E, 8'h00, 2, 3, 64, 4'h0);
        rd(1, mfrw_pkg::OP_QUAD_WORD, 4, 24'h000541, 24'h000540, 8'h20, 2, 1, 64, 4'h0);
        rd(0, 8'h00, 4, 24'h000561, 24'h000560, 8'h00, 2, 2, 64, 4'h0);
        check("cont", 24'(cont), 24'h000000);
        set_wrap(8'h70);
        rd(1, mfrw_pkg::OP_QUAD_IO, 4, 24'h00013E, 24'h00013E, 8'h00, 4, 3, 0, 4'h0);
        $display("wrap test done");
    endtask
    task t_qpi();
        int n0;
        set_wrap(8'h00);
        four_line_command_mode = 1'b1;
        repeat (3) @(negedge i_clk);
        check("wrap cfg", 24'(wcfg), 24'h000000);
        for (int p = 0; p < 4; p++) begin
            pdum = 2'(p);
            rd(4, mfrw_pkg::OP_QUAD_IO, 4, 24'h000606, 24'h000606, 8'h00, (p == 0) ? 2 : (p == 1) ? 4 : 6,
                4, 0, 4'h0);
        end
        rd(4, mfrw_pkg::OP_QUAD_IO, 4, 24'h000700, 24'h000700, 8'h20, 6, 1, 0, 4'h0);
        check("cont", 24'(cont), 24'h000001);
        rd(0, 8'h00, 4, 24'h000707, 24'h000707, 8'h00, 6, 2, 0, 4'h0);
        pwl = 2'h3;
        prl = 1'b1;
        @(negedge i_clk);
        prl = 1'b0;
        repeat (3) @(negedge i_clk);
        check("wrap cfg", 24'(wcfg), 24'h000003);
        n0 = nreq;
        u_host.start_frame();
        u_host.send(32'(mfrw_pkg::OP_DUAL_IO), 8, 4);
        u_host.dummy(20);
        check("oe", 24'(doe_n), 24'h00000F);
        u_host.stop_frame();
        check("requests", 24'(nreq - n0), 24'h000000);
        four_line_command_mode = 1'b0;
        $display("four-line test done");
    endtask
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        t_reset();
        t_dual();
        t_refuse();
        t_quad();
        t_wrap();
        t_qpi();
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge i_clk);
        $display("[FAIL] run time limit expected end seen hang");
        errors++;
        end_of_test();
    end
endmodule
